// *** i2c_target_pkg.sv ***
// Shared constants and types for the two-wire register target port
package i2c_target_pkg;

	// ----------------------------------------------------------------
	// Widths and bit counts
	// ----------------------------------------------------------------
	localparam int          BYTE_W    = 8;
	localparam int          CNT_W     = 4;
	localparam logic [3:0]  BYTE_BITS = 4'h8;
	localparam logic [3:0]  ACK_BIT   = 4'h9;

	// ----------------------------------------------------------------
	// Target address options
	// ----------------------------------------------------------------
	localparam logic [6:0]  OWN_ADDR_DEF = 7'h4D;
	localparam logic [6:0]  OWN_ADDR_ALT = 7'h4E;
	localparam logic [7:0]  CFG_ADDR_REG = 8'h7C;
	localparam int          ADDR_SEL_BIT = 7;

	// ----------------------------------------------------------------
	// Timing: fast-mode clock low period against the reference clock
	// ----------------------------------------------------------------
	localparam int          REF_PERIOD_NS = 40;
	localparam int          FAST_LOW_NS   = 1300;
	localparam int          FAST_LOW_CYC  = FAST_LOW_NS / REF_PERIOD_NS;

	// ----------------------------------------------------------------
	// Protocol states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_ADDR  = 7'h02,
		S_PTR   = 7'h04,
		S_WDATA = 7'h08,
		S_ACK   = 7'h10,
		S_RDATA = 7'h20,
		S_MACK  = 7'h40
	} tgt_state_t;

endpackage

// *** two_flop_sync.sv ***
// Two-stage synchroniser for levels entering the reference clock domain
`timescale 1ns/10ps
module two_flop_sync #(
	parameter int WIDTH = 1
) (
	// Clock, reset, enable
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);

	logic [WIDTH-1:0] meta_q;

	// First stage is read only by the second stage
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= '0;
			o_q    <= '0;
		end else if (i_ce) begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end

endmodule

// *** i2c_register_target_port.sv ***
// Two-wire target port giving a host read and write access to internal registers
`timescale 1ns/10ps
module i2c_register_target_port (
	// Clocks, reset and enable
	input  wire logic                              i_ref_clk,
	input  wire logic                              i_scl_clk,
	input  wire logic                              i_rst,
	input  wire logic                              i_ce,
	// Bus data pin, open drain
	input  wire logic                              i_sda,
	output logic                                   o_sda_o,
	output logic                                   o_sda_oe,
	// Configuration byte holding the address option
	input  wire logic [i2c_target_pkg::BYTE_W-1:0] i_cfg_misc2,
	// Register read side
	output logic      [i2c_target_pkg::BYTE_W-1:0] o_reg_addr,
	output logic                                   o_reg_rd,
	input  wire logic [i2c_target_pkg::BYTE_W-1:0] i_reg_rdata,
	// Register write side
	output logic                                   o_reg_wr,
	output logic      [i2c_target_pkg::BYTE_W-1:0] o_reg_waddr,
	output logic      [i2c_target_pkg::BYTE_W-1:0] o_reg_wdata
);
	import i2c_target_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic              link_tog_q;
	logic              link_bit_q;
	logic [2:0]        sync_w;
	logic [2:0]        prev_q;
	logic              tog_s, scl_s, sda_s;
	logic              rise_ev, fall_ev, start_ev, stop_ev;
	logic [6:0]        own_w;
	logic              load_w;
	tgt_state_t        state_q, state_d;
	tgt_state_t        nxt_q, nxt_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic [BYTE_W-1:0] sh_q, sh_d;
	logic [BYTE_W-1:0] tx_q, tx_d;
	logic [BYTE_W-1:0] ptr_q, ptr_d;
	logic [BYTE_W-1:0] waddr_q, waddr_d;
	logic [BYTE_W-1:0] wdata_q, wdata_d;
	logic              oe_q, oe_d;
	logic              mack_q, mack_d;
	logic              wr_q, wr_d;
	logic              rd_q, rd_d;
	logic [7:0]        low_cnt_q;

	// Address option decode
	function automatic logic [6:0] pick_addr(input logic sel);
		pick_addr = sel ? OWN_ADDR_ALT : OWN_ADDR_DEF;
	endfunction

	// ----------------------------------------------------------------
	// Link clock domain: capture data on each rising bus clock
	// ----------------------------------------------------------------
	// Toggle marks a new bit; the bit stays put for a whole bus period,
	// far longer than the synchroniser needs to pass the toggle over
	always_ff @(posedge i_scl_clk or posedge i_rst) begin
		if (i_rst) begin
			link_tog_q <= 1'b0;
			link_bit_q <= 1'b0;
		end else begin
			link_tog_q <= ~link_tog_q;
			link_bit_q <= i_sda;
		end
	end

	// ----------------------------------------------------------------
	// Crossing into the reference domain
	// ----------------------------------------------------------------
	two_flop_sync #(
		.WIDTH (3)
	) u_sync (
		.i_clk (i_ref_clk),
		.i_rst (i_rst),
		.i_ce  (i_ce),
		.i_d   ({link_tog_q, i_scl_clk, i_sda}),
		.o_q   (sync_w)
	);

	// Previous synchronised levels for edge finding
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			prev_q <= 3'h0;
		end else if (i_ce) begin
			prev_q <= sync_w;
		end
	end

	// Bus events; START and STOP need the clock high on both samples
	assign tog_s    = sync_w[2];
	assign scl_s    = sync_w[1];
	assign sda_s    = sync_w[0];
	assign rise_ev  = tog_s ^ prev_q[2];
	assign fall_ev  = prev_q[1] & ~scl_s;
	assign start_ev = scl_s & prev_q[1] & prev_q[0] & ~sda_s;
	assign stop_ev  = scl_s & prev_q[1] & ~prev_q[0] & sda_s;
	assign own_w    = pick_addr(i_cfg_misc2[ADDR_SEL_BIT]);

	// Next read byte is fetched after an address ack or a host ack
	assign load_w = fall_ev && (cnt_q == ACK_BIT) &&
		(((state_q == S_ACK) && (nxt_q == S_RDATA)) || ((state_q == S_MACK) && mack_q));

	// ----------------------------------------------------------------
	// Protocol engine, next state
	// ----------------------------------------------------------------
	// START and STOP win over bit events so a broken byte is dropped
	always_comb begin
		state_d = state_q;
		nxt_d   = nxt_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		tx_d    = tx_q;
		ptr_d   = ptr_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		oe_d    = oe_q;
		mack_d  = mack_q;
		wr_d    = 1'b0;
		rd_d    = 1'b0;
		if (stop_ev) begin
			state_d = S_IDLE;
			oe_d    = 1'b0;
			cnt_d   = '0;
		end else if (start_ev) begin
			state_d = S_ADDR;
			oe_d    = 1'b0;
			cnt_d   = '0;
		end else if (rise_ev && (state_q != S_IDLE)) begin
			cnt_d = CNT_W'(cnt_q + 4'h1);
			sh_d  = {sh_q[BYTE_W-2:0], link_bit_q};
			if (state_q == S_MACK) begin
				mack_d = ~link_bit_q;
			end
		end else if (load_w) begin
			cnt_d   = '0;
			state_d = S_RDATA;
			tx_d    = i_reg_rdata;
			oe_d    = ~i_reg_rdata[BYTE_W-1];
			rd_d    = 1'b1;
		end else if (fall_ev) begin
			case (state_q)
				S_ADDR: begin
					if (cnt_q == BYTE_BITS) begin
						if (sh_q[7:1] == own_w) begin
							oe_d    = 1'b1;
							state_d = S_ACK;
							nxt_d   = sh_q[0] ? S_RDATA : S_PTR;
						end else begin
							state_d = S_IDLE;
						end
					end
				end
				S_PTR: begin
					if (cnt_q == BYTE_BITS) begin
						ptr_d   = sh_q;
						oe_d    = 1'b1;
						state_d = S_ACK;
						nxt_d   = S_WDATA;
					end
				end
				S_WDATA: begin
					if (cnt_q == BYTE_BITS) begin
						wr_d    = 1'b1;
						waddr_d = ptr_q;
						wdata_d = sh_q;
						ptr_d   = BYTE_W'(ptr_q + 8'h01);
						oe_d    = 1'b1;
						state_d = S_ACK;
						nxt_d   = S_WDATA;
					end
				end
				S_ACK: begin
					if (cnt_q == ACK_BIT) begin
						oe_d    = 1'b0;
						cnt_d   = '0;
						state_d = nxt_q;
					end
				end
				S_RDATA: begin
					if (cnt_q == BYTE_BITS) begin
						oe_d    = 1'b0;
						ptr_d   = BYTE_W'(ptr_q + 8'h01);
						state_d = S_MACK;
					end else begin
						tx_d = {tx_q[BYTE_W-2:0], 1'b0};
						oe_d = ~tx_q[BYTE_W-2];
					end
				end
				S_MACK: begin
					if (cnt_q == ACK_BIT) begin
						oe_d    = 1'b0;
						cnt_d   = '0;
						state_d = S_IDLE;
					end
				end
				default: begin
					state_d = S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Protocol engine, registers
	// ----------------------------------------------------------------
	// Pin enable only moves on a clock-low event, except that START and STOP release it with clock high
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= S_IDLE;
			nxt_q   <= S_IDLE;
			cnt_q   <= '0;
			sh_q    <= 8'h00;
			tx_q    <= 8'h00;
			ptr_q   <= 8'h00;
			waddr_q <= 8'h00;
			wdata_q <= 8'h00;
			oe_q    <= 1'b0;
			mack_q  <= 1'b0;
			wr_q    <= 1'b0;
			rd_q    <= 1'b0;
		end else if (i_ce) begin
			state_q <= state_d;
			nxt_q   <= nxt_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			tx_q    <= tx_d;
			ptr_q   <= ptr_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			oe_q    <= oe_d;
			mack_q  <= mack_d;
			wr_q    <= wr_d;
			rd_q    <= rd_d;
		end
	end

	// Outputs; the pin only ever pulls low
	assign o_sda_o     = 1'b0;
	assign o_sda_oe    = oe_q;
	assign o_reg_addr  = ptr_q;
	assign o_reg_rd    = rd_q;
	assign o_reg_wr    = wr_q;
	assign o_reg_waddr = waddr_q;
	assign o_reg_wdata = wdata_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Cycles spent with the bus clock low, for the speed margin check
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			low_cnt_q <= 8'h00;
		end else if (i_ce && scl_s) begin
			low_cnt_q <= 8'h00;
		end else if (i_ce && (low_cnt_q != 8'hFF)) begin
			low_cnt_q <= 8'(low_cnt_q + 8'h01);
		end
	end

	addr_nomatch_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && fall_ev && !start_ev && !stop_ev && (state_q == S_ADDR) && (cnt_q == BYTE_BITS)
		&& (sh_q[7:1] != own_w) |=> (state_q == S_IDLE) && !oe_q)
		else $error("address mismatch was not ignored");
	addr_value_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(oe_q) && ($past(state_q) == S_ADDR)
		|-> $past(sh_q[7:1]) == ($past(i_cfg_misc2[ADDR_SEL_BIT]) ? OWN_ADDR_ALT : OWN_ADDR_DEF))
		else $error("acknowledged a foreign address");
	msb_first_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && rise_ev && !start_ev && !stop_ev && (state_q != S_IDLE)
		|=> (sh_q[0] == $past(link_bit_q)) && (sh_q[7:1] == $past(sh_q[6:0])))
		else $error("bit not shifted in at the low end");
	oe_on_low_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$changed(oe_q) |-> !$past(scl_s) || $past(start_ev) || $past(stop_ev))
		else $error("data pin moved while clock high");
	idle_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_q == S_IDLE) && !start_ev |=> (state_q == S_IDLE) && !oe_q)
		else $error("left idle without a START");
	ack_release_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && (state_q == S_ACK) && fall_ev && (cnt_q == ACK_BIT) && !start_ev && !stop_ev
		&& (nxt_q != S_RDATA) |=> !oe_q ##1 !oe_q)
		else $error("acknowledge not released after ninth clock");
	wr_ack_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		wr_q |-> (state_q == S_ACK) && oe_q && (nxt_q == S_WDATA))
		else $error("written byte not acknowledged");
	stop_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && stop_ev |=> !wr_q ##1 !wr_q)
		else $error("partial byte written at STOP");
	ptr_step_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		wr_q |-> (ptr_q == 8'(o_reg_waddr + 8'h01)))
		else $error("pointer did not advance after write");
	nack_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && (state_q == S_MACK) && fall_ev && (cnt_q == ACK_BIT) && !mack_q
		&& !start_ev && !stop_ev |=> (state_q == S_IDLE) && !oe_q)
		else $error("kept driving after host NACK");
	// Synchroniser and edge finding lag the pin by about three cycles
	speed_margin_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && $changed(oe_q) && !scl_s |-> (low_cnt_q + 3) < FAST_LOW_CYC)
		else $error("pin answer too late for the fast-mode low period");
	read_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		rd_q |-> (state_q == S_RDATA) && (oe_q == ~tx_q[BYTE_W-1]) && ($past(state_q) != S_RDATA))
		else $error("read byte not driven from its top bit");

	write_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) wr_q);
	read_seen_c:  cover property (@(posedge i_ref_clk) disable iff (i_rst) rd_q);
	nack_seen_c:  cover property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_q == S_MACK) && fall_ev && (cnt_q == ACK_BIT) && !mack_q);
	restart_c:    cover property (@(posedge i_ref_clk) disable iff (i_rst)
		start_ev && (state_q == S_ACK));

endmodule

// *** i2c_host_model.sv ***
// Host bus controller model that drives the two-wire bus from the reference clock
`timescale 1ns/10ps
module i2c_host_model (
	// Reference clock and resolved data line
	input  wire logic i_ref_clk,
	input  wire logic i_sda,
	// Bus clock and data pull-down
	output logic      o_scl,
	output logic      o_sda_low
);
	// Quarter bit in reference cycles: 17 is about 370 kHz, 63 about 99 kHz
	int q = 17;

	// Bus idles with both lines released
	initial begin
		o_scl     = 1'b1;
		o_sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask

	// ----------------------------------------------------------------
	// Bit level: data moves only mid-way through the clock low phase
	// ----------------------------------------------------------------
	task automatic put(input logic b);
		o_sda_low <= ~b;
		tick(q);
		o_scl <= 1'b1;
		tick(2 * q);
		o_scl <= 1'b0;
		tick(q);
	endtask

	task automatic get(output logic b);
		o_sda_low <= 1'b0;
		tick(q);
		o_scl <= 1'b1;
		tick(q);
		b = i_sda;
		tick(q);
		o_scl <= 1'b0;
		tick(q);
	endtask

	// ----------------------------------------------------------------
	// Frame level
	// ----------------------------------------------------------------
	// Handles both a first START and a repeated one
	task automatic start();
		if (!o_scl) begin
			o_sda_low <= 1'b0;
			tick(q);
			o_scl <= 1'b1;
			tick(2 * q);
		end
		o_sda_low <= 1'b1;
		tick(2 * q);
		o_scl <= 1'b0;
		tick(q);
	endtask

	// Bus free time of a full bit keeps well above the minimum
	task automatic stop();
		o_sda_low <= 1'b1;
		tick(q);
		o_scl <= 1'b1;
		tick(2 * q);
		o_sda_low <= 1'b0;
		tick(4 * q);
	endtask

	// Fewer than eight bits leaves a partial byte and skips the ack slot
	task automatic send(input logic [7:0] b, input int nbits, output logic ack);
		ack = 1'b1;
		if (o_scl) begin
			o_scl <= 1'b0;
			tick(q);
		end
		for (int i = 7; i > 7 - nbits; i--) begin
			put(b[i]);
		end
		if (nbits == 8) begin
			get(ack);
		end
	endtask

	task automatic recv(output logic [7:0] b, input logic last);
		for (int i = 7; i >= 0; i--) begin
			get(b[i]);
		end
		put(last);
	endtask
endmodule

// *** testbench.sv ***
// Self-checking testbench for the two-wire register target port
`timescale 1ns/10ps
module testbench;
	import i2c_target_pkg::*;

	logic        i_ref_clk;
	logic        i_rst;
	logic        i_sda;
	logic        scl;
	logic        host_low;
	logic        o_sda_o;
	logic        o_sda_oe;
	logic        o_reg_rd;
	logic        o_reg_wr;
	logic [7:0]  i_cfg_misc2;
	logic [7:0]  i_reg_rdata;
	logic [7:0]  o_reg_addr;
	logic [7:0]  o_reg_waddr;
	logic [7:0]  o_reg_wdata;
	logic [7:0]  mem [256];
	logic [7:0]  exp_mem [256];
	logic [31:0] lfsr_q = 32'h5054;
	int          n_fail = 0;
	int          checked = 0;
	int          n_wr = 0;
	int          n_rd = 0;

	// ----------------------------------------------------------------
	// Clock, bus wire and register file
	// ----------------------------------------------------------------
	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end

	// Pull-up wins unless a party pulls low
	assign i_sda = ~(host_low | (o_sda_oe & ~o_sda_o));
	assign i_reg_rdata = mem[o_reg_addr];

	always @(posedge i_ref_clk) begin
		if (o_reg_wr === 1'b1) begin
			mem[o_reg_waddr] <= o_reg_wdata;
			n_wr <= n_wr + 1;
		end
		if (o_reg_rd === 1'b1) begin
			n_rd <= n_rd + 1;
		end
	end

	i2c_host_model host (
		.i_ref_clk(i_ref_clk),
		.i_sda    (i_sda),
		.o_scl    (scl),
		.o_sda_low(host_low)
	);

	i2c_register_target_port uut (
		.i_ref_clk  (i_ref_clk),
		.i_scl_clk  (scl),
		.i_rst      (i_rst),
		.i_ce       (1'b1),
		.i_sda      (i_sda),
		.o_sda_o    (o_sda_o),
		.o_sda_oe   (o_sda_oe),
		.i_cfg_misc2(i_cfg_misc2),
		.o_reg_addr (o_reg_addr),
		.o_reg_rd   (o_reg_rd),
		.i_reg_rdata(i_reg_rdata),
		.o_reg_wr   (o_reg_wr),
		.o_reg_waddr(o_reg_waddr),
		.o_reg_wdata(o_reg_wdata)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function logic [7:0] rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q[7:0];
	endfunction

	function automatic logic [6:0] own_addr(input logic sel);
		return sel ? OWN_ADDR_ALT : OWN_ADDR_DEF;
	endfunction

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Unacknowledged bytes must leave the register file untouched
	task automatic wr_txn(input logic [6:0] a, input logic [7:0] ptr, input int n, input logic ok);
		logic       ack;
		logic [7:0] d;
		int         nw;
		nw = n_wr;
		host.start();
		host.send({a, 1'b0}, 8, ack);
		check({7'h00, ack}, {7'h00, ~ok});
		host.send(ptr, 8, ack);
		check({7'h00, ack}, {7'h00, ~ok});
		for (int i = 0; i < n; i++) begin
			d = rnd();
			host.send(d, 8, ack);
			check({7'h00, ack}, {7'h00, ~ok});
			if (ok) begin
				exp_mem[8'(ptr + i)] = d;
			end
		end
		host.stop();
		check(8'(n_wr - nw), ok ? 8'(n) : 8'h00);
	endtask

	// Last byte is refused, then one more byte is clocked to see the line stay free
	task automatic rd_txn(input logic [6:0] a, input logic [7:0] ptr, input int n);
		logic       ack;
		logic [7:0] d;
		int         nr;
		nr = n_rd;
		host.start();
		host.send({a, 1'b0}, 8, ack);
		check({7'h00, ack}, 8'h00);
		host.send(ptr, 8, ack);
		check({7'h00, ack}, 8'h00);
		host.start();
		host.send({a, 1'b1}, 8, ack);
		check({7'h00, ack}, 8'h00);
		for (int i = 0; i < n; i++) begin
			host.recv(d, i == n - 1);
			check(d, exp_mem[8'(ptr + i)]);
		end
		check(8'(n_rd - nr), 8'(n));
		check(o_reg_addr, 8'(ptr + n));
		host.recv(d, 1'b1);
		check(d, 8'hFF);
		host.stop();
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic       ack;
		logic [7:0] p;
		int         nw;
		i_rst       = 1'b1;
		i_cfg_misc2 = 8'h00;
		for (int i = 0; i < 256; i++) begin
			mem[i]     = 8'(i) ^ 8'hA5;
			exp_mem[i] = 8'(i) ^ 8'hA5;
		end
		repeat (4) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		repeat (6) @(posedge i_ref_clk);
		// A matching address clocked without a START is ignored
		host.send({own_addr(1'b0), 1'b0}, 8, ack);
		check({7'h00, ack}, 8'h01);
		host.stop();
		$display("test no_start done");
		for (int s = 0; s < 2; s++) begin
			i_cfg_misc2 <= {s[0], 7'(rnd())};
			@(posedge i_ref_clk);
			// Second pass crosses the pointer wrap
			p = s ? 8'hFE : rnd();
			wr_txn(own_addr(s[0]), p, 3, 1'b1);
			rd_txn(own_addr(s[0]), p, 3);
			wr_txn(own_addr(~s[0]), p, 1, 1'b0);
			nw = n_wr;
			host.start();
			host.send({own_addr(s[0]), 1'b0}, 8, ack);
			host.send(p, 8, ack);
			host.send(rnd(), 4, ack);
			host.stop();
			check(8'(n_wr - nw), 8'h00);
			rd_txn(own_addr(s[0]), p, 3);
			$display("test address option %0d done", s);
		end
		// Standard-mode bus rate
		host.q = 63;
		p = rnd();
		wr_txn(own_addr(1'b1), p, 2, 1'b1);
		rd_txn(own_addr(1'b1), p, 2);
		$display("test standard mode done");
		print_verdict();
	end

	// Hang guard
	initial begin
		repeat (90000) @(posedge i_ref_clk);
		n_fail++;
		print_verdict();
	end
endmodule
